/* expander_regs.svh */
// Register offsets, field positions and reset values of the port expander.
`ifndef EXPANDER_REGS_SVH
`define EXPANDER_REGS_SVH

// Offsets within one port's bank; address bit 4 picks the port.
`define PIN_DIRECTION_OFS 4'h0
`define CHANGE_IRQ_EN_OFS 4'h2
`define COMPARE_DEFAULT_OFS 4'h3
`define CHANGE_SOURCE_OFS 4'h4
`define EXPANDER_CONFIG_OFS 4'h5
`define PULLUP_ENABLE_OFS 4'h6
`define INTERRUPT_FLAGS_OFS 4'h7
`define INTERRUPT_CAPTURE_OFS 4'h8
`define PORT_VALUE_OFS 4'h9
`define OUTPUT_LATCH_OFS 4'ha
`define PORT_SEL_BIT 4

// Configuration register fields.
`define CFG_MIRROR_BIT 6
`define CFG_OPEN_DRAIN_BIT 2
`define CFG_POLARITY_BIT 1
`define CFG_WRITE_MASK 8'h46

// Reset values.
`define ZERO_BYTE 8'h00
`define DIR_RESET 8'hff
`define IRQ_OUT_RESET 1'b1

// Nominal weak pull-up, in kilohm.
`define PULLUP_KOHM 100

`endif

/* expander_pkg.sv */
// Types shared by the port expander design.
package expander_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [4:0] reg_addr_t;
endpackage

/* expander_port.sv */
// Two-port latch, pin readback and change interrupt logic of the expander.
`timescale 1ns/1ps
`include "expander_regs.svh"

// How it works
// - Pull-up output active only for bits with pull-up enabled and pin input.
// - Flag register is read-only; writes to it change nothing.
// - Flags set only for enabled pins and mark the pins causing the interrupt.
// - Capture loads pin levels at interrupt and holds until port/capture read.
// - Port read returns pin levels; port write goes to the output latch.
// - Output latch read returns latch contents, not pins.
// - Latch drives pins configured as outputs; inputs only store it.
// - Each pin has its own enable and its own compare source.
// - Two interrupt outputs, one per port; each cleared by its port read.
// - Mirror off: own output only; mirror on: ORed onto both outputs.
// - Mirrored: a read clears only its own port's interrupt.
// - Only enabled input pins can raise an interrupt.
// - Writes to port or capture register leave interrupt state alone.
// - Read clears the interrupt only after the byte's last bit went out.
// - Only the first event loads capture; later ones wait for clearing.
// - A still pending condition re-raises the interrupt after a port read.
// - Previous-value mode: reference becomes the pin level on clearing.
// - Default-compare mode: condition persists while pin differs from default.
// - Outputs selectable active-low, active-high push-pull, or open-drain.
// - Configuration bit 6 set selects mirrored interrupt outputs.
// - Configuration bit 2 set gives open-drain and overrides polarity.
// - Configuration bit 1 set gives active-high, clear gives active-low.
// - Compare bit one compares with default, zero with previous value.
module expander_port (
	input wire logic core_clk_i, // System clock, 100 MHz.
	input wire logic rst_i, // Asynchronous reset, active high.
	input wire logic link_clk_i, // Serial register link clock.
	input wire expander_pkg::reg_addr_t link_addr_i, // Register address.
	input wire logic link_wr_i, // Write strobe, one link cycle.
	input wire expander_pkg::byte_t link_wdata_i, // Write data.
	input wire logic link_rd_i, // Read request, one link cycle.
	input wire logic link_rd_done_i, // Last bit of read byte shifted out.
	output expander_pkg::byte_t link_rdata_o, // Read data.
	output logic link_rvalid_o, // Read data valid, one link cycle.
	input wire expander_pkg::byte_t port_a_pins_i, // First port pin levels.
	output expander_pkg::byte_t port_a_pins_o, // First port drive levels.
	output expander_pkg::byte_t port_a_pins_oe_o, // First port drive enables.
	output expander_pkg::byte_t port_a_pullup_o, // First port pull-ups on.
	input wire expander_pkg::byte_t port_b_pins_i, // Second port pin levels.
	output expander_pkg::byte_t port_b_pins_o, // Second port drive levels.
	output expander_pkg::byte_t port_b_pins_oe_o, // Second port drive enables.
	output expander_pkg::byte_t port_b_pullup_o, // Second port pull-ups on.
	output logic irq_out_a_o, // Interrupt output A level.
	output logic irq_out_a_oe_o, // Interrupt output A drive enable.
	output logic irq_out_b_o, // Interrupt output B level.
	output logic irq_out_b_oe_o // Interrupt output B drive enable.
);
	import expander_pkg::*;

	// ************************************************************
	// Link side capture
	// ************************************************************
	// Each request kind flips its own toggle; the captured address and
	// data stay put for many core cycles, so the core reads them safely
	// once the synchronised toggle shows a change.
	reg_addr_t wr_addr_lk_ff;
	byte_t wr_data_lk_ff;
	reg_addr_t rd_addr_lk_ff;
	logic wr_tgl_ff;
	logic rd_tgl_ff;
	logic done_tgl_ff;
	logic [2:0] ack_sync_ff;
	byte_t rdata_ff;
	logic ack_tgl_ff;

	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_addr_lk_ff <= '0;
			wr_data_lk_ff <= `ZERO_BYTE;
			wr_tgl_ff <= 1'b0;
		end else if (link_wr_i) begin
			wr_addr_lk_ff <= link_addr_i;
			wr_data_lk_ff <= link_wdata_i;
			wr_tgl_ff <= ~wr_tgl_ff;
		end
	end

	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_addr_lk_ff <= '0;
			rd_tgl_ff <= 1'b0;
		end else if (link_rd_i) begin
			rd_addr_lk_ff <= link_addr_i;
			rd_tgl_ff <= ~rd_tgl_ff;
		end
	end

	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			done_tgl_ff <= 1'b0;
		end else if (link_rd_done_i) begin
			done_tgl_ff <= ~done_tgl_ff;
		end
	end

	// Read data returns as a word held still while the ack toggle crosses.
	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_sync_ff <= 3'h0;
			link_rdata_o <= `ZERO_BYTE;
			link_rvalid_o <= 1'b0;
		end else begin
			ack_sync_ff <= {ack_sync_ff[1:0], ack_tgl_ff};
			link_rvalid_o <= ack_sync_ff[2] ^ ack_sync_ff[1];
			if (ack_sync_ff[2] ^ ack_sync_ff[1]) begin
				link_rdata_o <= rdata_ff;
			end
		end
	end

	// ************************************************************
	// Core side request detection
	// ************************************************************
	logic [2:0] wr_sync_ff;
	logic [2:0] rd_sync_ff;
	logic [2:0] done_sync_ff;
	logic wr_evt;
	logic rd_evt;
	logic done_evt;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_sync_ff <= 3'h0;
			rd_sync_ff <= 3'h0;
			done_sync_ff <= 3'h0;
		end else begin
			wr_sync_ff <= {wr_sync_ff[1:0], wr_tgl_ff};
			rd_sync_ff <= {rd_sync_ff[1:0], rd_tgl_ff};
			done_sync_ff <= {done_sync_ff[1:0], done_tgl_ff};
		end
	end

	assign wr_evt = wr_sync_ff[2] ^ wr_sync_ff[1];
	assign rd_evt = rd_sync_ff[2] ^ rd_sync_ff[1];
	assign done_evt = done_sync_ff[2] ^ done_sync_ff[1];

	// ************************************************************
	// Shared configuration
	// ************************************************************
	byte_t cfg_ff;
	logic cfg_wr;

	assign cfg_wr = wr_evt && wr_addr_lk_ff[3:0] == `EXPANDER_CONFIG_OFS;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_ff <= `ZERO_BYTE;
		end else if (cfg_wr) begin
			cfg_ff <= wr_data_lk_ff & `CFG_WRITE_MASK;
		end
	end

	// ************************************************************
	// Per-port registers and change detection
	// ************************************************************
	byte_t pin_in [2];
	byte_t pin_s1_ff [2];
	byte_t pin_s2_ff [2];
	byte_t dir_ff [2];
	byte_t en_ff [2];
	byte_t compare_default_ff [2];
	byte_t src_ff [2];
	byte_t pu_ff [2];
	byte_t output_latch_ff [2];
	byte_t flags_ff [2];
	byte_t cap_ff [2];
	byte_t ref_ff [2];
	byte_t elig [2];
	byte_t cond [2];
	byte_t rd_val [2];
	byte_t pins_out_ff [2];
	byte_t pins_oe_ff [2];
	byte_t pullup_ff [2];
	logic [1:0] pend_ff;
	logic [1:0] clr;

	assign pin_in[0] = port_a_pins_i;
	assign pin_in[1] = port_b_pins_i;

	for (genvar p = 0; p < 2; p++) begin : g_port
		logic wr_here;
		logic rd_here;

		assign wr_here = wr_evt && wr_addr_lk_ff[`PORT_SEL_BIT] == 1'(p);
		assign rd_here = rd_addr_lk_ff[`PORT_SEL_BIT] == 1'(p);
		// Clearing waits for the end of the read byte, not its start.
		assign clr[p] = done_evt && rd_here &&
			(rd_addr_lk_ff[3:0] == `PORT_VALUE_OFS ||
			rd_addr_lk_ff[3:0] == `INTERRUPT_CAPTURE_OFS);

		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				pin_s1_ff[p] <= `ZERO_BYTE;
				pin_s2_ff[p] <= `ZERO_BYTE;
			end else begin
				pin_s1_ff[p] <= pin_in[p];
				pin_s2_ff[p] <= pin_s1_ff[p];
			end
		end

		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				dir_ff[p] <= `DIR_RESET;
				en_ff[p] <= `ZERO_BYTE;
				compare_default_ff[p] <= `ZERO_BYTE;
				src_ff[p] <= `ZERO_BYTE;
				pu_ff[p] <= `ZERO_BYTE;
				output_latch_ff[p] <= `ZERO_BYTE;
			end else if (wr_here) begin
				// Flag and capture offsets have no case: writes drop.
				unique case (wr_addr_lk_ff[3:0])
					`PIN_DIRECTION_OFS: dir_ff[p] <= wr_data_lk_ff;
					`CHANGE_IRQ_EN_OFS: en_ff[p] <= wr_data_lk_ff;
					`COMPARE_DEFAULT_OFS: compare_default_ff[p] <= wr_data_lk_ff;
					`CHANGE_SOURCE_OFS: src_ff[p] <= wr_data_lk_ff;
					`PULLUP_ENABLE_OFS: pu_ff[p] <= wr_data_lk_ff;
					`PORT_VALUE_OFS: output_latch_ff[p] <= wr_data_lk_ff;
					`OUTPUT_LATCH_OFS: output_latch_ff[p] <= wr_data_lk_ff;
					default: ;
				endcase
			end
		end

		// Only enabled input pins take part; outputs never interrupt.
		assign elig[p] = en_ff[p] & dir_ff[p];
		// Per bit: one compares with the default, zero with the reference.
		assign cond[p] = elig[p] & ((src_ff[p] & (pin_s2_ff[p] ^ compare_default_ff[p]))
			| (~src_ff[p] & (pin_s2_ff[p] ^ ref_ff[p])));

		// The reference follows pins not enabled as inputs and holds for enabled input pins until a clear.
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				ref_ff[p] <= `ZERO_BYTE;
			end else if (clr[p]) begin
				ref_ff[p] <= pin_s2_ff[p];
			end else begin
				ref_ff[p] <= (ref_ff[p] & elig[p]) | (pin_s2_ff[p] & ~elig[p]);
			end
		end

		// A condition still present after clearing raises a fresh
		// interrupt on the next cycle, with a new capture.
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				pend_ff[p] <= 1'b0;
				flags_ff[p] <= `ZERO_BYTE;
				cap_ff[p] <= `ZERO_BYTE;
			end else if (pend_ff[p]) begin
				if (clr[p]) begin
					pend_ff[p] <= 1'b0;
					flags_ff[p] <= `ZERO_BYTE;
				end
			end else if (|cond[p]) begin
				pend_ff[p] <= 1'b1;
				flags_ff[p] <= cond[p];
				cap_ff[p] <= pin_s2_ff[p];
			end
		end

		always_comb begin
			unique case (rd_addr_lk_ff[3:0])
				`PIN_DIRECTION_OFS: rd_val[p] = dir_ff[p];
				`CHANGE_IRQ_EN_OFS: rd_val[p] = en_ff[p];
				`COMPARE_DEFAULT_OFS: rd_val[p] = compare_default_ff[p];
				`CHANGE_SOURCE_OFS: rd_val[p] = src_ff[p];
				`EXPANDER_CONFIG_OFS: rd_val[p] = cfg_ff;
				`PULLUP_ENABLE_OFS: rd_val[p] = pu_ff[p];
				`INTERRUPT_FLAGS_OFS: rd_val[p] = flags_ff[p];
				`INTERRUPT_CAPTURE_OFS: rd_val[p] = cap_ff[p];
				`PORT_VALUE_OFS: rd_val[p] = pin_s2_ff[p];
				`OUTPUT_LATCH_OFS: rd_val[p] = output_latch_ff[p];
				default: rd_val[p] = `ZERO_BYTE;
			endcase
		end

		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				pins_out_ff[p] <= `ZERO_BYTE;
				pins_oe_ff[p] <= `ZERO_BYTE;
				pullup_ff[p] <= `ZERO_BYTE;
			end else begin
				pins_out_ff[p] <= output_latch_ff[p];
				pins_oe_ff[p] <= ~dir_ff[p];
				pullup_ff[p] <= pu_ff[p] & dir_ff[p];
			end
		end

		a_first_capture: assert property (@(posedge core_clk_i) disable iff (rst_i)
			!pend_ff[p] && |cond[p] |=> pend_ff[p] &&
			cap_ff[p] == $past(pin_s2_ff[p]))
			else $error("first change did not capture the port");
		a_capture_holds: assert property (@(posedge core_clk_i) disable iff (rst_i)
			pend_ff[p] && $past(pend_ff[p]) |-> $stable(cap_ff[p]) &&
			$stable(flags_ff[p]))
			else $error("capture changed while interrupt pending");
		a_flags_need_enable: assert property (@(posedge core_clk_i)
			disable iff (rst_i)
			$rose(pend_ff[p]) |-> (flags_ff[p] & ~$past(elig[p])) == 8'h00)
			else $error("flag set for a pin not enabled as input");
		a_read_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
			clr[p] && pend_ff[p] |=> !pend_ff[p] && flags_ff[p] == 8'h00)
			else $error("port or capture read did not clear interrupt");
		a_write_no_clear: assert property (@(posedge core_clk_i)
			disable iff (rst_i)
			wr_here && pend_ff[p] && !clr[p] |=> pend_ff[p])
			else $error("register write altered interrupt state");
		a_latch_drives: assert property (@(posedge core_clk_i) disable iff (rst_i)
			wr_here && wr_addr_lk_ff[3:0] == `PORT_VALUE_OFS |->
			##2 pins_out_ff[p] == $past(wr_data_lk_ff, 2))
			else $error("port write did not reach the pin drivers");
	end

	// ************************************************************
	// Read return and interrupt outputs
	// ************************************************************
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= `ZERO_BYTE;
			ack_tgl_ff <= 1'b0;
		end else if (rd_evt) begin
			rdata_ff <= rd_val[rd_addr_lk_ff[`PORT_SEL_BIT]];
			ack_tgl_ff <= ~ack_tgl_ff;
		end
	end

	logic mirror;
	logic [1:0] irq_act;
	logic [1:0] irq_lvl_ff;
	logic [1:0] irq_oe_ff;

	assign mirror = cfg_ff[`CFG_MIRROR_BIT];
	assign irq_act[0] = mirror ? |pend_ff : pend_ff[0];
	assign irq_act[1] = mirror ? |pend_ff : pend_ff[1];

	// Open-drain only ever pulls low, so the polarity bit is ignored there.
	for (genvar i = 0; i < 2; i++) begin : g_irq
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				irq_lvl_ff[i] <= `IRQ_OUT_RESET;
				irq_oe_ff[i] <= `IRQ_OUT_RESET;
			end else if (cfg_ff[`CFG_OPEN_DRAIN_BIT]) begin
				irq_lvl_ff[i] <= 1'b0;
				irq_oe_ff[i] <= irq_act[i];
			end else begin
				irq_lvl_ff[i] <= cfg_ff[`CFG_POLARITY_BIT] ~^ irq_act[i];
				irq_oe_ff[i] <= 1'b1;
			end
		end
	end

	a_mirror_both: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		mirror |-> (irq_act == {2{|pend_ff}}) ##1
		(irq_lvl_ff[0] == irq_lvl_ff[1] && irq_oe_ff[0] == irq_oe_ff[1]))
		else $error("mirrored outputs disagree");
	a_open_drain: assert property (@(posedge core_clk_i) disable iff (rst_i)
		cfg_ff[`CFG_OPEN_DRAIN_BIT] |=> irq_lvl_ff == 2'b00)
		else $error("open-drain output drove high");

	assign port_a_pins_o = pins_out_ff[0];
	assign port_a_pins_oe_o = pins_oe_ff[0];
	assign port_a_pullup_o = pullup_ff[0];
	assign port_b_pins_o = pins_out_ff[1];
	assign port_b_pins_oe_o = pins_oe_ff[1];
	assign port_b_pullup_o = pullup_ff[1];
	assign irq_out_a_o = irq_lvl_ff[0];
	assign irq_out_a_oe_o = irq_oe_ff[0];
	assign irq_out_b_o = irq_lvl_ff[1];
	assign irq_out_b_oe_o = irq_oe_ff[1];

endmodule // expander_port

/* link_host.sv */
// Host controller model that drives the serial register link.
`timescale 1ns/1ps
module link_host (
	input wire logic link_clk_i, // Link clock.
	output expander_pkg::reg_addr_t link_addr_o, // Register address.
	output logic link_wr_o, // Write pulse.
	output expander_pkg::byte_t link_wdata_o, // Write data.
	output logic link_rd_o, // Read pulse.
	output logic link_rd_done_o, // Last bit of byte shifted out.
	input wire expander_pkg::byte_t link_rdata_i, // Read data.
	input wire logic link_rvalid_i // Read answer valid.
);
	import expander_pkg::*;
	initial begin
		link_addr_o = 5'h00;
		link_wr_o = 1'b0;
		link_wdata_o = 8'h00;
		link_rd_o = 1'b0;
		link_rd_done_o = 1'b0;
	end
	task automatic wr(input reg_addr_t a, input byte_t d);
		@(posedge link_clk_i);
		link_addr_o <= a;
		link_wdata_o <= d;
		link_wr_o <= 1'b1;
		@(posedge link_clk_i);
		link_wr_o <= 1'b0;
		// Released data is scrambled so a late sample cannot match.
		link_wdata_o <= ~d;
	endtask
	task automatic rd(input reg_addr_t a, output byte_t d, output bit ok);
		int n;
		@(posedge link_clk_i);
		link_addr_o <= a;
		link_rd_o <= 1'b1;
		@(posedge link_clk_i);
		link_rd_o <= 1'b0;
		n = 0;
		while (link_rvalid_i !== 1'b1 && n < 8) begin
			@(posedge link_clk_i);
			n++;
		end
		d = link_rdata_i;
		ok = (n < 8);
		// The clear comes only once the last bit has left the device.
		link_rd_done_o <= 1'b1;
		@(posedge link_clk_i);
		link_rd_done_o <= 1'b0;
	endtask
endmodule // link_host

/* port_latch_and_change_interrupt_tb_top.sv */
// Self-checking bench for the port expander latch and interrupt logic.
`timescale 1ns/1ps
module port_latch_and_change_interrupt_tb_top;
	import expander_pkg::*;
	logic core_clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic rst_i = 1'b1;
	reg_addr_t addr;
	logic wr, rd, rd_done, rvalid, ia, ia_oe, ib, ib_oe;
	byte_t wdata, rdata, pa_i, pb_i, pa_o, pb_o, pa_oe, pb_oe, pa_pu, pb_pu;
	byte_t pa_ext = 8'h00;
	byte_t pb_ext = 8'h00;
	byte_t mdl [0:31];
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	byte_t got, v, e;
	bit ok;
	// ******************************************
	// Pin wires and design
	// ******************************************
	assign pa_i = (pa_oe & pa_o) | (~pa_oe & pa_ext);
	assign pb_i = (pb_oe & pb_o) | (~pb_oe & pb_ext);
	expander_port u_expander_port (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.link_clk_i(link_clk_i), .link_addr_i(addr), .link_wr_i(wr),
		.link_wdata_i(wdata), .link_rd_i(rd), .link_rd_done_i(rd_done),
		.link_rdata_o(rdata), .link_rvalid_o(rvalid),
		.port_a_pins_i(pa_i), .port_a_pins_o(pa_o),
		.port_a_pins_oe_o(pa_oe), .port_a_pullup_o(pa_pu),
		.port_b_pins_i(pb_i), .port_b_pins_o(pb_o),
		.port_b_pins_oe_o(pb_oe), .port_b_pullup_o(pb_pu),
		.irq_out_a_o(ia), .irq_out_a_oe_o(ia_oe),
		.irq_out_b_o(ib), .irq_out_b_oe_o(ib_oe));
	link_host u_link_host (.link_clk_i(link_clk_i), .link_addr_o(addr),
		.link_wr_o(wr), .link_wdata_o(wdata), .link_rd_o(rd),
		.link_rd_done_o(rd_done), .link_rdata_i(rdata),
		.link_rvalid_i(rvalid));
	initial forever #5 core_clk_i = ~core_clk_i;
	initial begin
		#3.7;
		forever #80 link_clk_i = ~link_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			$display("ERROR timeout expected %0d seen %0d", 40000, cyc);
			final_report();
		end
	end
	// ******************************************
	// Tasks
	// ******************************************
	task automatic chk8(input string n, input byte_t x, input byte_t g);
		compares++;
		if (g !== x) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic chk1(input string n, input logic x, input logic g);
		compares++;
		if (g !== x) begin
			err_count++;
			$display("ERROR %s expected %b seen %b", n, x, g);
		end
	endtask
	task automatic rd_chk(input string n, input reg_addr_t a, input byte_t x);
		u_link_host.rd(a, got, ok);
		chk1("read_answer", 1'b1, ok);
		chk8(n, x, got);
		repeat (2) @(posedge link_clk_i);
	endtask
	task automatic wr_reg(input reg_addr_t a, input byte_t d);
		mdl[a] = d;
		u_link_host.wr(a, d);
		repeat (3) @(posedge link_clk_i);
	endtask
	task automatic pins(input byte_t a, input byte_t b);
		@(posedge core_clk_i);
		pa_ext <= a;
		pb_ext <= b;
		repeat (8) @(posedge core_clk_i);
	endtask
	task automatic chk_irq(input bit act_a, input bit act_b);
		byte_t c;
		bit a, b;
		c = mdl[5];
		a = c[6] ? (act_a | act_b) : act_a;
		b = c[6] ? (act_a | act_b) : act_b;
		if (c[2]) begin
			chk1("irq_a_oe", a, ia_oe);
			chk1("irq_b_oe", b, ib_oe);
			chk1("irq_a_od", 1'b0, ia);
			chk1("irq_b_od", 1'b0, ib);
		end else begin
			chk1("irq_a", a ~^ c[1], ia);
			chk1("irq_b", b ~^ c[1], ib);
			chk1("irq_a_pp", 1'b1, ia_oe);
			chk1("irq_b_pp", 1'b1, ib_oe);
		end
	endtask
	task automatic final_report();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ******************************************
	// Main sequence
	// ******************************************
	initial begin
		v = $urandom(32'hdad210c6);
		foreach (mdl[i]) mdl[i] = 8'h00;
		repeat (16) @(posedge core_clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge link_clk_i);
		rd_chk("pullup_a", 5'h06, 8'h00);
		rd_chk("flags_a", 5'h07, 8'h00);
		rd_chk("latch_b", 5'h1a, 8'h00);
		rd_chk("unmapped", 5'h0b, 8'h00);
		chk_irq(0, 0);
		$display("test reset done");
		for (int p = 0; p < 2; p++) begin
			reg_addr_t b;
			b = 5'(p * 16);
			v = 8'($urandom);
			e = 8'($urandom);
			wr_reg(b | 5'h00, 8'h0f);
			wr_reg(b | 5'h09, v);
			pins(e, e);
			rd_chk("latch", b | 5'h0a, v);
			rd_chk("port", b | 5'h09, (v & 8'hf0) | (e & 8'h0f));
			chk8("pins_o", v, p ? pb_o : pa_o);
			chk8("pins_oe", 8'hf0, p ? pb_oe : pa_oe);
			wr_reg(b | 5'h06, 8'hff);
			chk8("pullup", 8'h0f, p ? pb_pu : pa_pu);
			wr_reg(b | 5'h07, 8'hff);
			rd_chk("flags_ro", b | 5'h07, 8'h00);
		end
		$display("test latch done");
		wr_reg(5'h00, 8'hff);
		wr_reg(5'h10, 8'hff);
		pins(8'h00, 8'h00);
		wr_reg(5'h02, 8'h01);
		pins(8'h02, 8'h00);
		chk_irq(0, 0);
		pins(8'h03, 8'h00);
		chk_irq(1, 0);
		pins(8'h02, 8'h00);
		rd_chk("flags", 5'h07, 8'h01);
		wr_reg(5'h08, 8'h00);
		wr_reg(5'h09, 8'h00);
		chk_irq(1, 0);
		rd_chk("capture", 5'h08, 8'h03);
		chk_irq(0, 0);
		pins(8'h03, 8'h00);
		chk_irq(1, 0);
		rd_chk("port_a", 5'h09, 8'h03);
		chk_irq(0, 0);
		wr_reg(5'h00, 8'hfe);
		wr_reg(5'h0a, 8'h01);
		chk_irq(0, 0);
		$display("test change done");
		wr_reg(5'h05, 8'h40);
		wr_reg(5'h14, 8'h01);
		wr_reg(5'h12, 8'h01);
		pins(8'h02, 8'h01);
		chk_irq(0, 1);
		rd_chk("port_b", 5'h19, 8'h01);
		chk_irq(0, 1);
		wr_reg(5'h00, 8'hff);
		pins(8'h03, 8'h01);
		chk_irq(1, 1);
		rd_chk("port_a", 5'h09, 8'h03);
		chk_irq(0, 1);
		pins(8'h03, 8'h00);
		rd_chk("port_b", 5'h19, 8'h00);
		chk_irq(0, 0);
		$display("test mirror done");
		foreach (mdl[i]) if (i == 0) e = 8'h03;
		for (int k = 1; k < 4; k++) begin
			wr_reg(5'h05, 8'(k * 2));
			chk_irq(0, 0);
			e = e ^ 8'h01;
			pins(e, 8'h00);
			chk_irq(1, 0);
			rd_chk("port_a", 5'h09, e);
			chk_irq(0, 0);
		end
		$display("test output mode done");
		final_report();
	end
endmodule // port_latch_and_change_interrupt_tb_top
